// ===== rtl/bds_top.v
// Bridge drive sequencer: clock choice, dead time, clamp and protection
`timescale 1ns/10ps
`default_nettype none
`include "bds_defines.vh"
// Operation
// - Toggling external clock is halved into complementary bridge phases.
// - Steady clock-select level for six oscillator cycles selects internal oscillator.
// - Floating (high) select runs low rate, confirmed after six high cycles.
// - Grounded select runs high rate, confirmed after six low cycles.
// - Low-side gates have equal high widths with a both-low gap.
// - Dead time follows oscillator low phase, longer at lower rate.
// - Dead time starts only after both low-side gates read off.
// - Phase zero: high-side one and low-side two on, others off.
// - Phase one: high-side two and low-side one on, others off.
// - Over-limit current enters clamp mode, reducing low-side gate drive.
// - Over-temperature forces all four switches off.
// - Leave protection only when cool and cool-down elapsed.
// - Start-up begins clamped; full drive once current drops.
// - Enable high runs and closes pull-up bypass; low shuts down, opens it.
// - Internal low rate 250 kHz, high rate 350 kHz.
// - Floating enable counts as on; held low disables.
module bds_top #(
  parameter COOL_CYCLES = `BDS_COOL_CYCLES
) (
  // Clock and reset
  input  wire  sys_clk_i,
  input  wire  rstn_i,
  // Pins and analog monitors (asynchronous)
  input  wire  clk_sel_i,
  input  wire  enable_i,
  input  wire  over_limit_i,
  input  wire  over_temp_i,
  input  wire  temp_recovered_i,
  input  wire  gate_one_off_i,
  input  wire  gate_two_off_i,
  // Bridge switch commands
  output reg   high_side_switch_one_o,
  output reg   high_side_switch_two_o,
  output reg   low_side_gate_one_o,
  output reg   low_side_gate_two_o,
  // Drive strength and mode status
  output reg   reduced_drive_o,
  output reg   pullup_bypass_switch_o,
  output reg   ext_clock_mode_o,
  output reg   protect_mode_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs
  wire [6:0] sy;
  bds_sync #(.W(7)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .d_i       ({clk_sel_i, enable_i, over_limit_i, over_temp_i,
                 temp_recovered_i, gate_one_off_i, gate_two_off_i}),
    .q_o       (sy)
  );
  wire sel_s   = sy[6];
  wire en_s    = sy[5];
  wire lim_s   = sy[4];
  wire hot_s   = sy[3];
  wire cool_s  = sy[2];
  wire g1off_s = sy[1];
  wire g2off_s = sy[0];

  ////////////////////////////////////////////////////////////////////////////
  // Internal oscillator, rate from the last steady select level
  reg  high_rate;
  wire osc_level;
  wire osc_rise;
  bds_osc u_osc (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .high_rate_i (high_rate),
    .osc_level_o (osc_level),
    .osc_rise_o  (osc_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock source detection
  reg       sel_d;
  reg [2:0] steady_cnt;
  reg       ext_mode;
  reg [1:0] settle;
  wire      settled  = (settle == 2'h3);
  wire      sel_edge = settled & (sel_s ^ sel_d);
  wire      sel_rise = settled & sel_s & ~sel_d;

  // Hold off edge detection until the synchroniser carries the real pin
  // level; its reset value would otherwise read as a select edge
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      settle <= 2'h0;
    end else if (!settled) begin
      settle <= settle + 2'h1;
    end
  end

  // Any edge on select means external clock; six quiet cycles fall back
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sel_d      <= 1'b0;
      steady_cnt <= 3'h0;
      ext_mode   <= 1'b0;
      high_rate  <= 1'b0;
    end else begin
      sel_d <= sel_s;
      if (sel_edge) begin
        steady_cnt <= 3'h0;
        ext_mode   <= 1'b1;
      end else if (osc_rise) begin
        if (steady_cnt >= `BDS_STEADY_CYCLES - 1) begin
          ext_mode  <= 1'b0;
          high_rate <= ~sel_s;
        end else begin
          steady_cnt <= steady_cnt + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching clock: oscillator, or select pin itself in external mode
  reg  sw_level_d;
  wire sw_level = ext_mode ? sel_s : osc_level;
  wire sw_rise  = ext_mode ? sel_rise : osc_rise;
  wire sw_low   = ~sw_level;

  ////////////////////////////////////////////////////////////////////////////
  // Enable, start-up clamp and protection
  reg        run;
  reg        protect;
  reg        clamp;
  reg [15:0] cool_cnt;
  wire       cool_done = (cool_cnt >= COOL_CYCLES[15:0]);

  // Protection, clamp and enable state
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      run      <= 1'b0;
      protect  <= 1'b0;
      clamp    <= 1'b1;
      cool_cnt <= 16'h0000;
    end else begin
      run <= en_s;
      if (hot_s && !protect) begin
        protect  <= 1'b1;
        cool_cnt <= 16'h0000;
      end else if (protect) begin
        if (osc_rise && !cool_done)
          cool_cnt <= cool_cnt + 16'h0001;
        if (cool_done && cool_s && !hot_s)
          protect <= 1'b0;
      end
      // Restart after shutdown begins clamped again
      if (!run || protect)
        clamp <= 1'b1;
      else if (lim_s)
        clamp <= 1'b1;
      else
        clamp <= 1'b0;
    end
  end
  wire active = run & ~protect;

  ////////////////////////////////////////////////////////////////////////////
  // Switching clock falling edge ends a drive window
  wire sw_fall = sw_level_d & ~sw_level;

  // Delayed switching clock level for edge detection
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sw_level_d <= 1'b0;
    end else begin
      sw_level_d <= sw_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diagonal decode, shared by all four switch commands
  function diag_on;
    input drv;
    input ph;
    input want;
    begin
      diag_on = drv && (ph == want);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bridge sequencer: drive on clock high, wait for gates off, dead on low
  localparam ST_IDLE  = 2'h0;
  localparam ST_DRIVE = 2'h1;
  localparam ST_WOFF  = 2'h2;
  localparam ST_DEAD  = 2'h3;
  reg [1:0] state;
  reg [1:0] next_state;
  reg       phase;

  // Next-state logic; one diagonal per switching clock period, so the
  // bridge runs at half the switching clock in both source modes
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (active && sw_rise)
          next_state = ST_DRIVE;
      end
      ST_DRIVE: begin
        if (!active)
          next_state = ST_IDLE;
        else if (sw_fall)
          next_state = ST_WOFF;
      end
      ST_WOFF: begin
        if (!active)
          next_state = ST_IDLE;
        else if (g1off_s && g2off_s)
          next_state = ST_DEAD;
      end
      ST_DEAD: begin
        if (!active)
          next_state = ST_IDLE;
        else if (!sw_low)
          next_state = ST_DRIVE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase flips only once both gates read off, never mid-drive
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      phase <= `BDS_PHASE_ZERO;
    end else if (state == ST_WOFF && next_state == ST_DEAD) begin
      phase <= ~phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered switch commands
  wire drive = (state == ST_DRIVE) && active;

  // Both phases share one drive window so widths match
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      high_side_switch_one_o <= 1'b0;
      high_side_switch_two_o <= 1'b0;
      low_side_gate_one_o    <= 1'b0;
      low_side_gate_two_o    <= 1'b0;
    end else begin
      high_side_switch_one_o <= diag_on(drive, phase, `BDS_PHASE_ZERO);
      low_side_gate_two_o    <= diag_on(drive, phase, `BDS_PHASE_ZERO);
      high_side_switch_two_o <= diag_on(drive, phase, `BDS_PHASE_ONE);
      low_side_gate_one_o    <= diag_on(drive, phase, `BDS_PHASE_ONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered drive strength and mode status
  // Reduced drive is the safe reset state: start-up always begins clamped
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      reduced_drive_o        <= 1'b1;
      pullup_bypass_switch_o <= 1'b0;
      ext_clock_mode_o       <= 1'b0;
      protect_mode_o         <= 1'b0;
    end else begin
      reduced_drive_o        <= clamp;
      pullup_bypass_switch_o <= en_s;
      ext_clock_mode_o       <= ext_mode;
      protect_mode_o         <= protect;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bds_defines.vh
// Timing constants and encodings for the bridge drive sequencer
`ifndef BDS_DEFINES_VH
`define BDS_DEFINES_VH
// System clock period in ps
`define BDS_SYS_CLK_PS      4000
// Internal oscillator rates in kHz
`define BDS_LOW_RATE_KHZ    250
`define BDS_HIGH_RATE_KHZ   350
// Half-period counts in system cycles (rounded down)
`define BDS_LOW_HALF_CYC    (1000000000 / (`BDS_LOW_RATE_KHZ * 2 * `BDS_SYS_CLK_PS))
`define BDS_HIGH_HALF_CYC   (1000000000 / (`BDS_HIGH_RATE_KHZ * 2 * `BDS_SYS_CLK_PS))
// Steady-level cycles before falling back to the oscillator
`define BDS_STEADY_CYCLES   6
// Cool-down length in oscillator cycles
`define BDS_COOL_CYCLES     1024
// Bridge phase encoding
`define BDS_PHASE_ZERO      1'b0
`define BDS_PHASE_ONE       1'b1
`endif

// ===== rtl/bds_osc.v
// Internal oscillator: divides system clock into a low or high rate tick
`timescale 1ns/10ps
`default_nettype none
`include "bds_defines.vh"
module bds_osc #(
  parameter LOW_HALF  = `BDS_LOW_HALF_CYC,
  parameter HIGH_HALF = `BDS_HIGH_HALF_CYC
) (
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       rstn_i,
  // Rate select
  input  wire       high_rate_i,
  // Oscillator outputs
  output reg        osc_level_o,
  output reg        osc_rise_o
);
  reg [11:0] cnt;
  wire [11:0] half_lim = high_rate_i ? HIGH_HALF[11:0] : LOW_HALF[11:0];

  // Free running half-period counter
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cnt         <= 12'h000;
      osc_level_o <= 1'b0;
      osc_rise_o  <= 1'b0;
    end else if (cnt >= half_lim - 12'h001) begin
      cnt         <= 12'h000;
      osc_level_o <= ~osc_level_o;
      osc_rise_o  <= ~osc_level_o;
    end else begin
      cnt        <= cnt + 12'h001;
      osc_rise_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bds_sync.v
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module bds_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         sys_clk_i,
  input  wire         rstn_i,
  // Data
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta;

  // First stage only feeds the second
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      meta <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== verif/bds_asserts.sv
// Port-level checker for the bridge drive sequencer
`timescale 1ns/10ps
`default_nettype none
module bds_asserts #(
  parameter COOL_CYCLES = 4
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // Pins and monitors
  input wire clk_sel_i,
  input wire enable_i,
  input wire over_limit_i,
  input wire over_temp_i,
  input wire temp_recovered_i,
  input wire gate_one_off_i,
  input wire gate_two_off_i,
  // Design outputs
  input wire high_side_switch_one_o,
  input wire high_side_switch_two_o,
  input wire low_side_gate_one_o,
  input wire low_side_gate_two_o,
  input wire reduced_drive_o,
  input wire pullup_bypass_switch_o,
  input wire ext_clock_mode_o,
  input wire protect_mode_o
);
  // One high-rate oscillator period, the shortest possible
  localparam int OSC_MIN = 714;
  wire       any_on = high_side_switch_one_o | high_side_switch_two_o | low_side_gate_one_o
                    | low_side_gate_two_o;
  reg [31:0] prot_len;
  reg [31:0] sel_quiet;
  reg        sel_d;
  // Time spent protected and since the last select edge
  always @(posedge sys_clk_i) begin
    sel_d     <= clk_sel_i;
    prot_len  <= (rstn_i && protect_mode_o) ? prot_len + 32'h1 : 32'h0;
    sel_quiet <= (!rstn_i || clk_sel_i != sel_d) ? 32'h0 : sel_quiet + 32'h1;
  end
  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_no_overlap; !(low_side_gate_one_o && low_side_gate_two_o); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("gate overlap");
  property p_ph0; low_side_gate_two_o |-> high_side_switch_one_o && !high_side_switch_two_o; endproperty
  a_ph0: assert property (p_ph0) else $error("phase zero wrong");
  property p_ph1; low_side_gate_one_o |-> high_side_switch_two_o && !high_side_switch_one_o; endproperty
  a_ph1: assert property (p_ph1) else $error("phase one wrong");
  property p_dead; $rose(low_side_gate_one_o) || $rose(low_side_gate_two_o)
    |-> $past(gate_one_off_i) && $past(gate_two_off_i); endproperty
  a_dead: assert property (p_dead) else $error("dead time before gates off");
  property p_prot_off; protect_mode_o |-> !any_on; endproperty
  a_prot_off: assert property (p_prot_off) else $error("switch on in protection");
  property p_prot_exit; $fell(protect_mode_o) |-> temp_recovered_i && !over_temp_i
    && prot_len > (COOL_CYCLES - 1) * OSC_MIN; endproperty
  a_prot_exit: assert property (p_prot_exit) else $error("early protection exit");
  property p_disable; !enable_i [*6] |-> !any_on && !pullup_bypass_switch_o && reduced_drive_o;
  endproperty
  a_disable: assert property (p_disable) else $error("runs while disabled");
  property p_clamp; over_limit_i [*6] |-> reduced_drive_o; endproperty
  a_clamp: assert property (p_clamp) else $error("no clamp on over limit");
  property p_int_ret; $fell(ext_clock_mode_o) |-> sel_quiet > 5 * OSC_MIN; endproperty
  a_int_ret: assert property (p_int_ret) else $error("early internal fallback");
  c_ext: cover property ($rose(ext_clock_mode_o));
  c_prot: cover property ($fell(protect_mode_o));
  c_clamp: cover property ($fell(reduced_drive_o));
endmodule
bind bds_top bds_asserts #(.COOL_CYCLES(COOL_CYCLES)) u_asserts (.*);
`default_nettype wire

// ===== verif/bds_power_stage.sv
// Power stage model: low-side gate off monitors
`timescale 1ns/10ps
`default_nettype none
module bds_power_stage (
  // Clock
  input  wire sys_clk_i,
  // Gate commands and off monitors
  input  wire gate_one_i,
  input  wire gate_two_i,
  output wire gate_one_off_o,
  output wire gate_two_off_o
);
  reg [2:0] hist_one = 3'h0;
  reg [2:0] hist_two = 3'h0;
  // Gate charge drains slowly, so off shows three cycles late
  always @(posedge sys_clk_i) begin
    hist_one <= {hist_one[1:0], gate_one_i};
    hist_two <= {hist_two[1:0], gate_two_i};
  end
  assign gate_one_off_o = ~|{hist_one, gate_one_i};
  assign gate_two_off_o = ~|{hist_two, gate_two_i};
endmodule
`default_nettype wire

// ===== verif/tb_bridge_drive_sequencer.sv
// Self-checking bench for the bridge drive sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_bridge_drive_sequencer;
  logic sys_clk_i, rstn_i, clk_sel_i, enable_i, over_limit_i, over_temp_i, temp_recovered_i;
  wire  gate_one_off_i, gate_two_off_i, high_side_switch_one_o, high_side_switch_two_o;
  wire  low_side_gate_one_o, low_side_gate_two_o, reduced_drive_o, pullup_bypass_switch_o;
  wire  ext_clock_mode_o, protect_mode_o;
  int   mismatches = 0;
  int   n_checks = 0;
  int   cyc = 0;
  int   w1, w2, dl, dh, de;
  logic ext_run = 1'b0;
  wire  any_on = high_side_switch_one_o | high_side_switch_two_o | low_side_gate_one_o
               | low_side_gate_two_o;

  bds_top #(.COOL_CYCLES(2)) dut (.*);
  bds_power_stage u_stage (.sys_clk_i(sys_clk_i), .gate_one_i(low_side_gate_one_o),
    .gate_two_i(low_side_gate_two_o), .gate_one_off_o(gate_one_off_i),
    .gate_two_off_o(gate_two_off_i));
  //////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // External clock source (period 40 cycles) and hang guard
  always @(negedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (ext_run && cyc % 20 == 0) clk_sel_i <= ~clk_sel_i;
    if (cyc == 100000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic go(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input string n, input logic s, input logic e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", n, e, s);
    end
  endtask
  // Widths of gate one high, dead gap, gate two high from a fresh rise
  task automatic meas(output int a, output int d, output int b);
    while (low_side_gate_one_o !== 1'b0) go(1);
    while (low_side_gate_one_o !== 1'b1) go(1);
    chk("phase_one", high_side_switch_two_o & ~high_side_switch_one_o, 1'b1);
    for (a = 0; low_side_gate_one_o === 1'b1; a++) go(1);
    for (d = 0; low_side_gate_two_o !== 1'b1; d++) go(1);
    chk("phase_zero", high_side_switch_one_o & ~high_side_switch_two_o, 1'b1);
    for (b = 0; low_side_gate_two_o === 1'b1; b++) go(1);
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Start-up, rate selection, external clock, protection, enable
  initial begin
    rstn_i = 1'b0;
    clk_sel_i = 1'b1;
    enable_i = 1'b1;
    over_limit_i = 1'b1;
    over_temp_i = 1'b0;
    temp_recovered_i = 1'b1;
    go(6);
    rstn_i = 1'b1;
    go(10);
    chk("start_clamp", reduced_drive_o, 1'b1);
    over_limit_i = 1'b0;
    go(6);
    chk("full_drive", reduced_drive_o, 1'b0);
    chk("pullup_on", pullup_bypass_switch_o, 1'b1);
    meas(w1, dl, w2);
    chk("low_equal", w1 == w2, 1'b1);
    chk("low_rate", w1 >= 498 && w1 <= 500, 1'b1);
    clk_sel_i = 1'b0;
    go(6);
    chk("ext_edge", ext_clock_mode_o, 1'b1);
    go(18000);
    chk("high_sel", ext_clock_mode_o, 1'b0);
    meas(w1, dh, w2);
    chk("high_rate", w1 >= 355 && w1 <= 357, 1'b1);
    chk("dead_scale", dl >= dh && dh > 0, 1'b1);
    ext_run = 1'b1;
    meas(w1, de, w2);
    meas(w1, de, w2);
    chk("ext_mode", ext_clock_mode_o, 1'b1);
    chk("ext_half", w1 + de > 38 && w1 + de < 42, 1'b1);
    chk("ext_equal", w1 == w2, 1'b1);
    ext_run = 1'b0;
    go(25);
    clk_sel_i = 1'b1;
    go(26000);
    chk("low_sel", ext_clock_mode_o, 1'b0);
    over_temp_i = 1'b1;
    go(6);
    chk("protect", protect_mode_o & ~any_on, 1'b1);
    over_temp_i = 1'b0;
    go(100);
    chk("cool_wait", protect_mode_o, 1'b1);
    temp_recovered_i = 1'b0;
    go(9000);
    chk("still_hot", protect_mode_o, 1'b1);
    temp_recovered_i = 1'b1;
    go(6);
    chk("recovered", protect_mode_o, 1'b0);
    over_limit_i = 1'b1;
    go(6);
    chk("clamp", reduced_drive_o, 1'b1);
    over_limit_i = 1'b0;
    enable_i = 1'b0;
    go(6);
    chk("disabled", pullup_bypass_switch_o | any_on, 1'b0);
    enable_i = 1'b1;
    go(6);
    chk("pullup_back", pullup_bypass_switch_o, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
